/* logic/ssi_pkg.sv */
// Shared constants, register map and types of the sensor shield register bank
package ssi_pkg;

  // ==========================================================================
  // Slave identity and link limits
  // ==========================================================================
  localparam logic [6:0]  SLAVE_ADDR    = 7'h42;
  localparam int          BUS_MAX_KBPS  = 400;
  localparam int          CLK_HZ        = 20_000_000;

  // ==========================================================================
  // Register offsets (byte pointer values)
  // ==========================================================================
  localparam logic [7:0]  OFS_DAC       = 8'h00;
  localparam logic [7:0]  OFS_LAMP_BITS = 8'h04;
  localparam logic [7:0]  OFS_LAMP_SEL  = 8'h05;
  localparam logic [7:0]  OFS_INPUT     = 8'h06;
  localparam logic [7:0]  OFS_TEMP      = 8'h07;
  localparam logic [7:0]  OFS_HUM       = 8'h0b;
  localparam logic [7:0]  OFS_LUX       = 8'h0f;
  localparam logic [7:0]  OFS_KNOB      = 8'h13;
  localparam logic [7:0]  OFS_END       = 8'h17;
  localparam int          NUM_RW        = 6;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          IN_TOUCH_LSB  = 0;
  localparam int          IN_MECH1_BIT  = 4;
  localparam int          IN_MECH2_BIT  = 5;
  localparam int          IN_PROX_BIT   = 6;
  localparam int          SEL_MANUAL_BIT = 0;

  // ==========================================================================
  // Reset values and fixed data
  // ==========================================================================
  localparam logic [31:0] RST_DAC       = 32'h0000_0000;
  localparam logic [7:0]  RST_LAMP_BITS = 8'h00;
  localparam logic [7:0]  RST_LAMP_SEL  = 8'h00;
  localparam logic [47:0] RST_RW_BYTES  = {RST_LAMP_SEL, RST_LAMP_BITS, RST_DAC};
  localparam logic [7:0]  OUT_OF_MAP    = 8'h00;
  localparam logic [31:0] FLOAT_ZERO    = 32'h0000_0000;
  localparam logic [31:0] FLOAT_2V4     = 32'h4019_999a;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          IRQ_PULSE_US  = 1500;
  localparam int          IRQ_PULSE_CYC = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int          BLINK_HALF_MS = 500;
  localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Slave protocol states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ, ST_READ_ACK
  } ssi_state_t;

  // Clamp a single-precision value into 0 .. 2.4; negatives go to zero
  function automatic logic [31:0] ssi_clamp_span(input logic [31:0] f);
    logic [31:0] r;
    r = f;
    if (f[31]) begin
      r = FLOAT_ZERO;
    end else if (f[30:0] > FLOAT_2V4[30:0]) begin
      r = FLOAT_2V4;
    end
    return r;
  endfunction

endpackage

/* logic/ssi_regfile.sv */
// Byte-addressed register file with writable bytes and registered read port
module ssi_regfile (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data,
  // Read port
  input  wire logic [7:0]  rd_addr,
  output logic      [7:0]  rd_data_ff,
  // Read-only sources
  input  wire logic [7:0]  input_flags,
  input  wire logic [31:0] temperature,
  input  wire logic [31:0] humidity,
  input  wire logic [31:0] light_lux,
  input  wire logic [31:0] knob_volts,
  // Writable contents
  output logic      [31:0] dac_word,
  output logic      [7:0]  lamp_bits,
  output logic      [7:0]  lamp_sel
);

  logic [7:0] rw_ff [ssi_pkg::NUM_RW];
  logic [7:0] nxt_rd_data;

  // ==========================================================================
  // Writable bytes; writes above them are taken and dropped
  // ==========================================================================
  for (genvar i = 0; i < ssi_pkg::NUM_RW; i++) begin : g_rw
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        rw_ff[i] <= ssi_pkg::RST_RW_BYTES[8*i +: 8];
      end else if (wr_en && (wr_addr == 8'(i))) begin
        rw_ff[i] <= wr_data;
      end
    end
  end

  // Byte lane of a float, least significant byte at the lowest offset
  function automatic logic [7:0] lane_of(input logic [31:0] w, input logic [1:0] lane);
    return w[{lane, 3'b000} +: 8];
  endfunction

  // ==========================================================================
  // Read decode
  // ==========================================================================
  always_comb begin
    nxt_rd_data = ssi_pkg::OUT_OF_MAP;
    if (rd_addr < ssi_pkg::OFS_INPUT) begin
      nxt_rd_data = rw_ff[3'(rd_addr)];
    end else if (rd_addr == ssi_pkg::OFS_INPUT) begin
      nxt_rd_data = input_flags;
    end else if (rd_addr < ssi_pkg::OFS_HUM) begin
      nxt_rd_data = lane_of(temperature, 2'(rd_addr - ssi_pkg::OFS_TEMP));
    end else if (rd_addr < ssi_pkg::OFS_LUX) begin
      nxt_rd_data = lane_of(humidity, 2'(rd_addr - ssi_pkg::OFS_HUM));
    end else if (rd_addr < ssi_pkg::OFS_KNOB) begin
      nxt_rd_data = lane_of(light_lux, 2'(rd_addr - ssi_pkg::OFS_LUX));
    end else if (rd_addr < ssi_pkg::OFS_END) begin
      nxt_rd_data = lane_of(knob_volts, 2'(rd_addr - ssi_pkg::OFS_KNOB));
    end
  end

  // Registered read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_data_ff <= ssi_pkg::OUT_OF_MAP;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign dac_word  = {rw_ff[3], rw_ff[2], rw_ff[1], rw_ff[0]};
  assign lamp_bits = rw_ff[4];
  assign lamp_sel  = rw_ff[5];

endmodule

/* logic/ssi_top.sv */
// Sensor shield coprocessor digital side: pointer-based two-wire slave and pin routing
module ssi_top #(
  parameter int IRQ_PULSE_CYC  = ssi_pkg::IRQ_PULSE_CYC,
  parameter int BLINK_HALF_CYC = ssi_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Two-wire slave pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  // Sensing inputs
  input  wire logic [3:0]  touch_key,
  input  wire logic        prox_detect,
  input  wire logic        mech_button_one_n,
  input  wire logic        mech_button_two_n,
  input  wire logic        boot_mode,
  // Measurement words from the conversion side
  input  wire logic [31:0] temperature_celsius,
  input  wire logic [31:0] humidity_percent,
  input  wire logic [31:0] light_level_lux,
  input  wire logic [31:0] knob_raw,
  // Host header pins
  input  wire logic        hdr_lamp_one_pin,
  input  wire logic        hdr_lamp_two_pin,
  output logic             hdr_button_one_pin,
  output logic             hdr_button_two_pin,
  output logic             hdr_touch_irq_pin,
  // Board lamps, active low
  output logic             user_lamp_one_n,
  output logic             user_lamp_two_n,
  output logic [3:0]       touch_lamp_n,
  output logic             prox_lamp_n,
  // Analog output setpoint
  output logic [31:0]      dac_setpoint_volts
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  ssi_pkg::ssi_state_t state_ff;
  logic        scl_q_ff, sda_q_ff;
  logic [7:0]  shift_ff, tx_ff;
  logic [2:0]  bit_cnt_ff;
  logic        byte_full_ff, first_ff, rw_ff, nack_ff;
  logic [7:0]  base_ptr_ff, ptr_ff;
  logic        wr_en_ff;
  logic [7:0]  wr_addr_ff, wr_data_ff, rd_data;
  logic [7:0]  input_flags_ff, lamp_bits, lamp_sel;
  logic [31:0] knob_sat_ff, dac_word;
  logic [3:0]  touch_prev_ff, nxt_lit;
  logic [31:0] irq_cnt_ff, blink_cnt_ff;
  logic        blink_ff;
  logic        scl_rise, scl_fall, start_det, stop_det;

  // ==========================================================================
  // Bus line edges and conditions
  // ==========================================================================
  // Previous samples; pins are already synchronous to clk_sys
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // A data change while the clock is high marks start or stop
  assign scl_rise  = scl_i & ~scl_q_ff;
  assign scl_fall  = ~scl_i & scl_q_ff;
  assign start_det = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_det  = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

  // ==========================================================================
  // Slave protocol engine
  // ==========================================================================
  // Outputs change only on clock falls; 400 kbps leaves about 25 cycles
  // of low phase at 20 MHz, ample for the two-cycle read data path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff     <= ssi_pkg::ST_IDLE;
      shift_ff     <= 8'h00;
      tx_ff        <= 8'h00;
      bit_cnt_ff   <= 3'h0;
      byte_full_ff <= 1'b0;
      first_ff     <= 1'b0;
      rw_ff        <= 1'b0;
      nack_ff      <= 1'b0;
      base_ptr_ff  <= 8'h00;
      ptr_ff       <= 8'h00;
      wr_en_ff     <= 1'b0;
      wr_addr_ff   <= 8'h00;
      wr_data_ff   <= 8'h00;
      sda_oe_n     <= 1'b1;
      sda_o        <= 1'b0; // Line only ever pulled low, level fixed at zero
    end else begin
      wr_en_ff <= 1'b0;
      if (start_det) begin
        // Repeated start is legal from any state
        state_ff     <= ssi_pkg::ST_ADDR;
        bit_cnt_ff   <= 3'h0;
        byte_full_ff <= 1'b0;
        sda_oe_n     <= 1'b1;
      end else if (stop_det) begin
        state_ff <= ssi_pkg::ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        unique case (state_ff)
          ssi_pkg::ST_IDLE: begin
          end
          ssi_pkg::ST_ADDR, ssi_pkg::ST_WRITE: begin
            if (scl_rise) begin
              shift_ff     <= {shift_ff[6:0], sda_i};
              bit_cnt_ff   <= bit_cnt_ff + 3'h1;
              byte_full_ff <= (bit_cnt_ff == 3'h7);
            end else if (scl_fall && byte_full_ff) begin
              byte_full_ff <= 1'b0;
              if (state_ff == ssi_pkg::ST_ADDR) begin
                if (shift_ff[7:1] == ssi_pkg::SLAVE_ADDR) begin
                  rw_ff    <= shift_ff[0];
                  ptr_ff   <= base_ptr_ff;
                  sda_oe_n <= 1'b0;
                  state_ff <= ssi_pkg::ST_ACK_ADDR;
                end else begin
                  state_ff <= ssi_pkg::ST_IDLE;
                end
              end else begin
                sda_oe_n <= 1'b0;
                state_ff <= ssi_pkg::ST_ACK_WRITE;
                if (first_ff) begin
                  first_ff    <= 1'b0;
                  base_ptr_ff <= shift_ff;
                  ptr_ff      <= shift_ff;
                end else begin
                  // Read-only targets are acknowledged; the file drops them
                  wr_en_ff   <= 1'b1;
                  wr_addr_ff <= ptr_ff;
                  wr_data_ff <= shift_ff;
                  ptr_ff     <= ptr_ff + 8'h01;
                end
              end
            end
          end
          ssi_pkg::ST_ACK_ADDR: begin
            if (scl_fall) begin
              bit_cnt_ff <= 3'h0;
              if (rw_ff) begin
                tx_ff    <= rd_data;
                sda_oe_n <= rd_data[7];
                ptr_ff   <= ptr_ff + 8'h01;
                state_ff <= ssi_pkg::ST_READ;
              end else begin
                first_ff <= 1'b1;
                sda_oe_n <= 1'b1;
                state_ff <= ssi_pkg::ST_WRITE;
              end
            end
          end
          ssi_pkg::ST_ACK_WRITE: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              state_ff <= ssi_pkg::ST_WRITE;
            end
          end
          ssi_pkg::ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_ff == 3'h7) begin
                sda_oe_n <= 1'b1;
                state_ff <= ssi_pkg::ST_READ_ACK;
              end else begin
                tx_ff      <= {tx_ff[6:0], 1'b0};
                sda_oe_n   <= tx_ff[6];
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
              end
            end
          end
          ssi_pkg::ST_READ_ACK: begin
            if (scl_rise) begin
              nack_ff <= sda_i;
            end else if (scl_fall) begin
              if (nack_ff) begin
                state_ff <= ssi_pkg::ST_IDLE;
              end else begin
                tx_ff      <= rd_data;
                sda_oe_n   <= rd_data[7];
                bit_cnt_ff <= 3'h0;
                ptr_ff     <= ptr_ff + 8'h01;
                state_ff   <= ssi_pkg::ST_READ;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  ssi_regfile u_regfile (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .wr_en       (wr_en_ff),
    .wr_addr     (wr_addr_ff),
    .wr_data     (wr_data_ff),
    .rd_addr     (ptr_ff),
    .rd_data_ff  (rd_data),
    .input_flags (input_flags_ff),
    .temperature (temperature_celsius),
    .humidity    (humidity_percent),
    .light_lux   (light_level_lux),
    .knob_volts  (knob_sat_ff),
    .dac_word    (dac_word),
    .lamp_bits   (lamp_bits),
    .lamp_sel    (lamp_sel)
  );

  // Status byte, saturated knob reading and setpoint held inside its honoured span
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      input_flags_ff     <= 8'h00;
      knob_sat_ff        <= ssi_pkg::FLOAT_ZERO;
      dac_setpoint_volts <= ssi_pkg::RST_DAC;
    end else begin
      input_flags_ff <= 8'h00;
      input_flags_ff[ssi_pkg::IN_TOUCH_LSB +: 4] <= touch_key;
      input_flags_ff[ssi_pkg::IN_MECH1_BIT] <= ~mech_button_one_n;
      input_flags_ff[ssi_pkg::IN_MECH2_BIT] <= ~mech_button_two_n;
      input_flags_ff[ssi_pkg::IN_PROX_BIT]  <= prox_detect;
      knob_sat_ff <= ssi_pkg::ssi_clamp_span(knob_raw);
      dac_setpoint_volts <= ssi_pkg::ssi_clamp_span(dac_word);
    end
  end

  // ==========================================================================
  // Touch lamps and proximity lamp
  // ==========================================================================
  // Manual byte or live keys, chosen by the source select bit
  assign nxt_lit = lamp_sel[ssi_pkg::SEL_MANUAL_BIT] ? lamp_bits[3:0] : touch_key;

  // Lamps are active low on the board
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      touch_lamp_n <= 4'hf;
      prox_lamp_n  <= 1'b1;
    end else begin
      touch_lamp_n <= ~nxt_lit;
      prox_lamp_n  <= ~prox_detect;
    end
  end

  // ==========================================================================
  // Touch change interrupt
  // ==========================================================================
  // A change during a pulse restarts it, so closely spaced changes merge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      touch_prev_ff     <= 4'h0;
      irq_cnt_ff        <= 32'h0000_0000;
      hdr_touch_irq_pin <= 1'b0;
    end else begin
      touch_prev_ff <= touch_key;
      if (touch_key != touch_prev_ff) begin
        irq_cnt_ff        <= 32'(IRQ_PULSE_CYC - 1);
        hdr_touch_irq_pin <= 1'b1;
      end else if (irq_cnt_ff != 32'h0000_0000) begin
        irq_cnt_ff <= irq_cnt_ff - 32'h0000_0001;
      end else begin
        hdr_touch_irq_pin <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Header routing and boot-mode blink
  // ==========================================================================
  // Half-period divider for the alternating boot indication
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blink_cnt_ff <= 32'h0000_0000;
      blink_ff     <= 1'b0;
    end else if (blink_cnt_ff == 32'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_ff <= 32'h0000_0000;
      blink_ff     <= ~blink_ff;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
    end
  end

  // Host lamp pins are ignored in boot mode; the header button pins follow the buttons in every mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hdr_button_one_pin <= 1'b1;
      hdr_button_two_pin <= 1'b1;
      user_lamp_one_n    <= 1'b1;
      user_lamp_two_n    <= 1'b1;
    end else begin
      hdr_button_one_pin <= mech_button_one_n;
      hdr_button_two_pin <= mech_button_two_n;
      if (boot_mode) begin
        user_lamp_one_n <= blink_ff;
        user_lamp_two_n <= ~blink_ff;
      end else begin
        user_lamp_one_n <= ~hdr_lamp_one_pin;
        user_lamp_two_n <= ~hdr_lamp_two_pin;
      end
    end
  end

endmodule

/* sim/ssi_bus_master.sv */
// Baseboard model: master of the two-wire register bus
module ssi_bus_master (
  // Clock and wire level
  input  wire logic clk_sys,
  input  wire logic sda_line,
  // Master drives, released high
  output logic      scl_o,
  output logic      sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // =================
  // Bus phases
  // =================
  initial begin
    scl_o = 1'b1;
    sda_oe_n = 1'b1;
  end

  // Four clocks a quarter keeps each clock phase at 8 cycles, 1.25 Mbps at 20 MHz, above 400 kbps
  task automatic qtr();
    repeat (4) @(negedge clk_sys);
  endtask

  // One bit: set while the clock is low, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_oe_n = b;
    qtr();
    scl_o = 1'b1;
    qtr();
    s = sda_line;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask

  // Byte MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] w, input logic a, output logic [7:0] r,
                         output logic s);
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(a, s);
  endtask

  // Whole transfer; multi-byte values travel least significant byte first
  task automatic xfer(input logic [7:0] adr, input int nb, input logic [39:0] wd,
                      output logic [31:0] rd, output logic ok);
    logic [7:0] b;
    logic       s;
    rd = 32'h0;
    sda_oe_n = 1'b0;
    qtr();
    scl_o = 1'b0;
    qtr();
    byte_io(adr, 1'b1, b, s);
    ok = !s;
    for (int i = 0; i < nb && ok; i++) begin
      if (adr[0]) begin
        byte_io(8'hff, i == nb - 1, b, s);
        rd[i*8 +: 8] = b;
      end else begin
        byte_io(wd[i*8 +: 8], 1'b1, b, s);
        ok = !s;
      end
    end
    sda_oe_n = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_oe_n = 1'b1;
    qtr();
  endtask
endmodule

/* sim/ssi_top_chk.sv */
// Pin-level checks of the sensor shield register bank
module ssi_top_chk #(
  parameter int IRQ_PULSE_CYC = ssi_pkg::IRQ_PULSE_CYC
) (
  // Clock, reset and bus pins
  input wire logic        clk_sys, rst_n, scl_i, sda_oe_n,
  // Sensing and routing pins
  input wire logic [3:0]  touch_key,
  input wire logic        prox_detect, mech_button_one_n, mech_button_two_n, boot_mode,
  input wire logic        hdr_lamp_one_pin, hdr_lamp_two_pin, hdr_button_one_pin,
  input wire logic        hdr_button_two_pin, hdr_touch_irq_pin, user_lamp_one_n,
  input wire logic        user_lamp_two_n, prox_lamp_n,
  // Analog setpoint
  input wire logic [31:0] dac_setpoint_volts
);
  timeunit 1ns;
  timeprecision 1ns;
  int         quiet_ff;
  logic [3:0] last_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // =================
  // Helper logic
  // =================
  // Cycles since the keys last moved; pulse length is judged on this, so retriggers pass
  always_ff @(posedge clk_sys) begin
    last_ff <= touch_key;
    quiet_ff <= (!rst_n || touch_key != last_ff) ? 0 : quiet_ff + 1;
  end

  // Routing outputs are one-register copies of their sources, lamps inverted; boot lamps alternate
  property p_btn; $past(rst_n) |-> hdr_button_one_pin == $past(mech_button_one_n)
    && hdr_button_two_pin == $past(mech_button_two_n); endproperty
  a_btn: assert property (p_btn) else $error("button copy wrong");
  property p_lamp; $past(rst_n) && !$past(boot_mode) |-> user_lamp_one_n ==
    !$past(hdr_lamp_one_pin) && user_lamp_two_n == !$past(hdr_lamp_two_pin); endproperty
  a_lamp: assert property (p_lamp) else $error("user lamp not inverted copy");
  property p_boot; $past(rst_n) && $past(boot_mode) |-> user_lamp_one_n != user_lamp_two_n;
  endproperty
  a_boot: assert property (p_boot) else $error("boot lamps not alternating");
  property p_prox; $past(rst_n) |-> prox_lamp_n == !$past(prox_detect); endproperty
  a_prox: assert property (p_prox) else $error("proximity lamp wrong");
  // Interrupt follows any key change quickly and lasts the programmed length
  property p_irq_on; $past(rst_n) && touch_key != $past(touch_key) |-> ##[1:2] hdr_touch_irq_pin;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("no interrupt on key change");
  property p_irq_max; hdr_touch_irq_pin |-> quiet_ff <= IRQ_PULSE_CYC + 2; endproperty
  a_irq_max: assert property (p_irq_max) else $error("interrupt too long");
  property p_irq_min; $fell(hdr_touch_irq_pin) |-> quiet_ff >= IRQ_PULSE_CYC; endproperty
  a_irq_min: assert property (p_irq_min) else $error("interrupt too short");
  property p_dac; !dac_setpoint_volts[31] && dac_setpoint_volts[30:0] <= 31'h4019_999a;
  endproperty
  a_dac: assert property (p_dac) else $error("setpoint outside span");
  // Data drive may only move while the bus clock is low
  property p_sda; $past(rst_n) && sda_oe_n != $past(sda_oe_n) |-> !scl_i && !$past(scl_i);
  endproperty
  a_sda: assert property (p_sda) else $error("data moved with clock high");
endmodule

bind ssi_top ssi_top_chk #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) u_ssi_top_chk (.*);

/* sim/tb_top.sv */
// Self-checking bench of the sensor shield register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // =================
  // Pins and tallies
  // =================
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl_i, sda_i, sda_o, sda_oe_n, m_oe_n, ok;
  logic        prox_detect = 1'b0;
  logic        mech_button_one_n = 1'b1;
  logic        mech_button_two_n = 1'b1;
  logic        boot_mode = 1'b0;
  logic        hdr_lamp_one_pin = 1'b0;
  logic        hdr_lamp_two_pin = 1'b0;
  logic [3:0]  touch_key = 4'h0;
  logic [3:0]  touch_lamp_n;
  logic [31:0] temperature_celsius = 32'h41c8_0000;
  logic [31:0] humidity_percent = 32'h4234_0000;
  logic [31:0] light_level_lux = 32'h43c8_0000;
  logic [31:0] knob_raw = 32'h4080_0000;
  logic [31:0] dac_setpoint_volts, rv;
  logic        hdr_button_one_pin, hdr_button_two_pin, hdr_touch_irq_pin;
  logic        user_lamp_one_n, user_lamp_two_n, prox_lamp_n;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  // Open-drain data wire with pull-up: low when either party pulls it
  assign sda_i = m_oe_n & (sda_oe_n | sda_o);
  always #25 clk_sys = ~clk_sys;

  // Short pulse and blink counts keep the run brief
  ssi_top #(.IRQ_PULSE_CYC(20), .BLINK_HALF_CYC(8)) u_ssi_top (.*);
  ssi_bus_master u_ssi_bus_master (.clk_sys, .sda_line(sda_i), .scl_o(scl_i), .sda_oe_n(m_oe_n));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write to slave 0x42: offset byte, then n data bytes
  task automatic wr_reg(input logic [7:0] ofs, input int n, input logic [31:0] d);
    u_ssi_bus_master.xfer(8'h84, n + 1, {d, ofs}, rv, ok);
    chk("write ack", 32'h1, {31'h0, ok});
  endtask

  task automatic rd_reg(input logic [7:0] ofs, input int n, input logic [31:0] e, input string w);
    wr_reg(ofs, 0, 32'h0);
    u_ssi_bus_master.xfer(8'h85, n, 40'h0, rv, ok);
    chk(w, e, rv);
  endtask

  task automatic t_dac();
    u_ssi_bus_master.xfer(8'h85, 4, 40'h0, rv, ok);
    chk("dac reset", 32'h0, rv);
    wr_reg(8'h00, 4, 32'h3fc0_0000);
    chk("dac out", 32'h3fc0_0000, dac_setpoint_volts);
    wr_reg(8'h00, 4, 32'h4040_0000);
    chk("dac clamp", 32'h4019_999a, dac_setpoint_volts);
    rd_reg(8'h00, 4, 32'h4040_0000, "dac read");
  endtask

  task automatic t_lamp();
    touch_key = 4'b0101;
    repeat (3) @(negedge clk_sys);
    chk("touch lamps", 32'ha, {28'h0, touch_lamp_n});
    chk("irq", 32'h1, {31'h0, hdr_touch_irq_pin});
    wr_reg(8'h04, 2, 32'h0109);
    chk("manual lamps", 32'h6, {28'h0, touch_lamp_n});
    chk("irq end", 32'h0, {31'h0, hdr_touch_irq_pin});
    wr_reg(8'h05, 1, 32'h0);
    chk("touch lamps back", 32'ha, {28'h0, touch_lamp_n});
  endtask

  // Read-only bytes ignore writes; mechanical button one reads as pressed
  task automatic t_status();
    mech_button_one_n = 1'b0;
    prox_detect = 1'b1;
    wr_reg(8'h06, 2, 32'hffff);
    rd_reg(8'h06, 1, 32'h55, "status");
    chk("hdr button one", 32'h0, {31'h0, hdr_button_one_pin});
    chk("prox lamp", 32'h0, {31'h0, prox_lamp_n});
    mech_button_one_n = 1'b1;
  endtask

  task automatic t_meas();
    rd_reg(8'h07, 4, 32'h41c8_0000, "temp");
    rd_reg(8'h0b, 4, 32'h4234_0000, "hum");
    rd_reg(8'h0f, 4, 32'h43c8_0000, "lux");
    rd_reg(8'h13, 4, 32'h4019_999a, "knob clamp");
    knob_raw = 32'hbf80_0000;
    rd_reg(8'h16, 2, 32'h0, "knob top and end");
    u_ssi_bus_master.xfer(8'h86, 2, 40'h0, rv, ok);
    chk("foreign address ack", 32'h0, {31'h0, ok});
  endtask

  task automatic t_route();
    hdr_lamp_one_pin = 1'b1;
    mech_button_two_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("user lamps", 32'h1, {30'h0, user_lamp_one_n, user_lamp_two_n});
    chk("hdr button two", 32'h0, {31'h0, hdr_button_two_pin});
    boot_mode = 1'b1;
    hdr_lamp_two_pin = 1'b1;
    repeat (2) @(negedge clk_sys);
    rv[0] = user_lamp_one_n;
    chk("boot lamps", 32'h1, {31'h0, user_lamp_one_n ^ user_lamp_two_n});
    repeat (8) @(negedge clk_sys);
    chk("boot blink", {31'h0, ~rv[0]}, {31'h0, user_lamp_one_n});
    boot_mode = 1'b0;
  endtask

  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, well above the length of all transfers
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_dac();
    t_lamp();
    t_status();
    t_meas();
    t_route();
    complete_run();
  end
endmodule
